// [core/multifunction_pin_function_select.sv]
// Purpose: select the function of a multifunction pin from a code
// Assumes: status bundle on clock; pin input asynchronous
// Notes: pin output and enable come straight from flops
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ns
`include "pin_mux_params.svh"
module multifunction_pin_function_select #(
  parameter int DIV_RATIO = `CLK_DIV_RATIO
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire pin_mux_pkg::status_bundle_t status_i,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_n,
  output logic update_pulse,
  output logic irq
);
  // --------------------------------------------------------------
  // local sizes
  // --------------------------------------------------------------
  // divider counter width; ratio must be a power of two
  localparam int DIV_W = $clog2(DIV_RATIO);

  // --------------------------------------------------------------
  // decode function
  // --------------------------------------------------------------
  // maps a code to the pin level; unknown codes give level 0
  function automatic pin_mux_pkg::pin_drive_t decode_fn(
    input logic [7:0] code,
    input pin_mux_pkg::status_bundle_t st,
    input logic div_bit
  );
    pin_mux_pkg::pin_drive_t r;
    r = '{level: 1'b0, known: 1'b1};
    // input codes never drive a level
    if (code == `FN_IN_IDLE || code == `FN_IN_UPDATE)
      r.level = 1'b0;
    else if (code == `FN_OUT_LOW)
      r.level = 1'b0;
    else if (code == `FN_OUT_HIGH)
      r.level = 1'b1;
    else if (code == `FN_OUT_DIV)
      r.level = div_bit;
    else if (code == `FN_OUT_WDT)
      r.level = st.watchdog;
    else if (code >= `FN_MEM_BASE && code < `FN_LOOP_BASE)
      r.level = st.mem_state[2'(code - `FN_MEM_BASE)];
    // loop range covers both the lock bits and calibration/reference
    else if (code >= `FN_LOOP_BASE && code < `FN_ALL_LOCK)
      r.level = st.loop_state[3'(code - `FN_LOOP_BASE)];
    // phase lock, analog lock and system loop lock
    else if (code == `FN_ALL_LOCK)
      r.level = st.mode_state[4] & st.loop_state[2] & st.loop_state[0];
    else if (code == `FN_TWO_LOCK)
      r.level = st.mode_state[4] & st.loop_state[2];
    // mode range
    else if (code >= `FN_MODE_BASE && code < `FN_CLAMP)
      r.level = st.mode_state[3'(code - `FN_MODE_BASE)];
    else if (code == `FN_CLAMP)
      r.level = st.freq_clamped;
    else if (code == `FN_HIST_AVAIL)
      r.level = st.hist_avail;
    else if (code == `FN_HIST_UPD)
      r.level = st.hist_updated;
    else if ((code & 8'hFC) == `FN_FAULT_BASE)
      r.level = st.ref_fault[code[1:0]];
    else if ((code & 8'hFC) == `FN_VALID_BASE)
      r.level = st.ref_valid[code[1:0]];
    else if ((code & 8'hFC) == `FN_ACTIVE_BASE)
      r.level = (st.ref_active == code[1:0]);
    else if (code == `FN_SYNC)
      r.level = st.sync_pulse;
    else if (code == `FN_SOFT_CFG)
      r.level = st.soft_cfg_busy;
    // reserved: inactive low, flagged unknown
    else
      r = '{level: 1'b0, known: 1'b0};
    return r;
  endfunction : decode_fn

  // --------------------------------------------------------------
  // register state
  // --------------------------------------------------------------
  logic [7:0] func_q;       // pin function code
  logic [2:0] irq_stat_q;   // sticky event bits
  logic [2:0] irq_mask_q;   // interrupt enables
  logic [7:0] rdata_q;      // read data, one cycle after strobe
  logic [DIV_W-1:0] div_q;  // free running clock divider
  logic sync1_q;            // pin synchroniser, first stage
  logic sync2_q;            // pin synchroniser, second stage
  logic sync3_q;            // delayed copy for edge detect
  logic pin_out_q;          // registered pin level
  logic pin_oe_n_q;         // registered enable, low drives
  logic update_q;           // register update trigger
  logic irq_q;              // registered interrupt level
  pin_mux_pkg::pin_drive_t drive_d; // decoded drive
  pin_mux_pkg::pin_dir_t dir;       // direction from code
  logic in_rise;            // synced rising edge on the pin
  logic update_d;           // next update trigger
  logic [2:0] irq_evt;      // events this cycle
  logic stat_wr;            // write to status register
  logic [2:0] irq_act;      // unmasked pending events

  // --------------------------------------------------------------
  // combinational decode
  // --------------------------------------------------------------
  assign dir = pin_mux_pkg::pin_dir_t'(func_q[`DIR_BIT]);
  assign drive_d = decode_fn(func_q, status_i, div_q[DIV_W-1]);
  assign in_rise = sync2_q & ~sync3_q;
  // only code 0x01 turns an input edge into an update
  assign update_d = (func_q == `FN_IN_UPDATE) & in_rise;
  assign stat_wr = reg_wr & (reg_addr == `REG_IRQ_STAT);
  assign irq_act = irq_stat_q & irq_mask_q;
  // events: update trigger, input edge, output level change
  always_comb
  begin
    irq_evt = 3'h0;
    irq_evt[`IRQ_UPDATE] = update_d;
    irq_evt[`IRQ_EDGE] = in_rise & (dir == pin_mux_pkg::DIR_INPUT)
                         & (func_q == `FN_IN_UPDATE);
    irq_evt[`IRQ_LEVEL] = (dir == pin_mux_pkg::DIR_OUTPUT)
                          & drive_d.known
                          & (drive_d.level != pin_out_q);
  end

  // --------------------------------------------------------------
  // function code register
  // --------------------------------------------------------------
  // any value is stored; reserved ones simply decode inactive
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      func_q <= `FUNC_RESET;
    end
    else if (reg_wr && reg_addr == `REG_FUNC)
    begin
      func_q <= reg_wdata;
    end
  end

  // --------------------------------------------------------------
  // interrupt mask register
  // --------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_mask_q <= 3'(`MASK_RESET);
    end
    else if (reg_wr && reg_addr == `REG_IRQ_MASK)
    begin
      irq_mask_q <= reg_wdata[2:0];
    end
  end

  // --------------------------------------------------------------
  // sticky status, write one to clear
  // --------------------------------------------------------------
  // a new event beats a clear in the same cycle, so none is lost
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_stat_q <= 3'h0;
    end
    else
    begin
      irq_stat_q <= (irq_stat_q & ~(stat_wr ? reg_wdata[2:0] : 3'h0))
                    | irq_evt;
    end
  end

  // --------------------------------------------------------------
  // interrupt output
  // --------------------------------------------------------------
  // registered so the port comes from a flop; one cycle late
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |irq_act;
    end
  end

  // --------------------------------------------------------------
  // read port
  // --------------------------------------------------------------
  // data stand only in the cycle after the strobe, else zero
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_q <= 8'h00;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        `REG_FUNC: rdata_q <= func_q;
        `REG_IRQ_STAT: rdata_q <= {5'h00, irq_stat_q};
        `REG_IRQ_MASK: rdata_q <= {5'h00, irq_mask_q};
        // live pin view: direction, synced input, driven level
        `REG_PIN_STATE: rdata_q <= {5'h00, func_q[`DIR_BIT], sync2_q, pin_out_q};
        default: rdata_q <= 8'h00; // unmapped reads zero
      endcase
    end
    else
    begin
      rdata_q <= 8'h00;
    end
  end

  // --------------------------------------------------------------
  // clock divider
  // --------------------------------------------------------------
  // free running, so the divided clock phase ignores code changes
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_q <= '0;
    end
    else
    begin
      div_q <= div_q + 1'b1;
    end
  end

  // --------------------------------------------------------------
  // pin input synchroniser
  // --------------------------------------------------------------
  // first stage feeds only the second stage
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end
    else
    begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // --------------------------------------------------------------
  // update trigger
  // --------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      update_q <= 1'b0;
    end
    else
    begin
      update_q <= update_d;
    end
  end

  // --------------------------------------------------------------
  // pin driver
  // --------------------------------------------------------------
  // input codes release the pin; level held low to stay defined
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_out_q <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end
    else
    begin
      pin_out_q <= drive_d.level;
      pin_oe_n_q <= (dir == pin_mux_pkg::DIR_INPUT);
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign reg_rdata = rdata_q;
  assign pin_out = pin_out_q;
  assign pin_oe_n = pin_oe_n_q;
  assign update_pulse = update_q;
  assign irq = irq_q;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  // synced pin rises while the update code is held
  sequence s_update_edge;
    (func_q == `FN_IN_UPDATE) && !sync2_q ##1
    (func_q == `FN_IN_UPDATE) && sync2_q;
  endsequence
  // one cycle update pulse then quiet
  sequence s_one_pulse;
    update_q ##1 !update_q;
  endsequence

  chk_const_low: assert property (
    func_q == `FN_OUT_LOW |=> !pin_out_q && !pin_oe_n_q)
    else $error("pin not low for code 0x80");
  chk_const_high: assert property (
    func_q == `FN_OUT_HIGH |=> pin_out_q && !pin_oe_n_q)
    else $error("pin not high for code 0x81");
  chk_input_release: assert property (
    !func_q[`DIR_BIT] |=> pin_oe_n_q && !pin_out_q)
    else $error("pin driven in input mode");
  chk_update_pulse: assert property (
    s_update_edge |=> s_one_pulse)
    else $error("update pulse missing or too long");
  chk_no_update: assert property (
    func_q != `FN_IN_UPDATE |=> !update_q)
    else $error("update pulse outside update code");
  chk_div_period: assert property (
    $rose(div_q[DIV_W-1]) |-> ##32 $rose(div_q[DIV_W-1]))
    else $error("divided clock period wrong");
  chk_div_drive: assert property (
    (func_q == `FN_OUT_DIV)[*2] |-> pin_out_q == $past(div_q[DIV_W-1]))
    else $error("divided clock not on pin");
  chk_wdt_mirror: assert property (
    func_q == `FN_OUT_WDT |=> pin_out_q == $past(status_i.watchdog))
    else $error("watchdog not mirrored");
  chk_mem_fault: assert property (
    func_q == 8'h86 |=> pin_out_q == $past(status_i.mem_state[2]))
    else $error("memory fault not mirrored");
  chk_loop_cal: assert property (
    func_q == 8'h8A |=> pin_out_q == $past(status_i.loop_state[3]))
    else $error("calibration state not mirrored");
  chk_all_lock: assert property (
    func_q == `FN_ALL_LOCK && !status_i.loop_state[0] |=> !pin_out_q)
    else $error("all lock high without system lock");
  chk_two_lock: assert property (
    func_q == `FN_TWO_LOCK && status_i.mode_state[4]
    && status_i.loop_state[2] |=> pin_out_q)
    else $error("two lock low with both locks");
  chk_mode_hold: assert property (
    func_q == 8'h92 |=> pin_out_q == $past(status_i.mode_state[2]))
    else $error("holdover not mirrored");
  chk_ref_fault: assert property (
    func_q == 8'hA3 |=> pin_out_q == $past(status_i.ref_fault[3]))
    else $error("reference d fault not mirrored");
  chk_ref_valid: assert property (
    func_q == 8'hB1 |=> pin_out_q == $past(status_i.ref_valid[1]))
    else $error("reference b valid not mirrored");
  chk_active_ref: assert property (
    func_q == 8'hC2 |=> pin_out_q == ($past(status_i.ref_active) == 2'h2))
    else $error("active reference c wrong");
  chk_reserved_low: assert property (
    func_q == 8'h8E |=> !pin_out_q && !update_q)
    else $error("reserved code drives or acts");
  chk_irq_level: assert property (
    (irq_act != 3'h0) |=> irq_q)
    else $error("interrupt missing for pending event");
  chk_set_wins: assert property (
    irq_evt[`IRQ_UPDATE] && stat_wr && reg_wdata[`IRQ_UPDATE]
    |=> irq_stat_q[`IRQ_UPDATE])
    else $error("event lost against clear");
endmodule : multifunction_pin_function_select

// [core/pin_mux_params.svh]
// Purpose: constants for the multifunction pin function select block
// Assumes: 8-bit register port, one system clock
// Notes: offsets are byte addresses on the plain register port
`ifndef PIN_MUX_PARAMS_SVH
`define PIN_MUX_PARAMS_SVH
// --------------------------------------------------------------
// register offsets and reset values
// --------------------------------------------------------------
`define REG_FUNC 8'h00
`define REG_IRQ_STAT 8'h01
`define REG_IRQ_MASK 8'h02
`define REG_PIN_STATE 8'h03
`define FUNC_RESET 8'h00
`define MASK_RESET 8'h00
// --------------------------------------------------------------
// field positions
// --------------------------------------------------------------
`define DIR_BIT 7
`define IRQ_UPDATE 0
`define IRQ_EDGE 1
`define IRQ_LEVEL 2
// --------------------------------------------------------------
// function codes
// --------------------------------------------------------------
`define FN_IN_IDLE 8'h00
`define FN_IN_UPDATE 8'h01
`define FN_OUT_LOW 8'h80
`define FN_OUT_HIGH 8'h81
`define FN_OUT_DIV 8'h82
`define FN_OUT_WDT 8'h83
`define FN_MEM_BASE 8'h84
`define FN_LOOP_BASE 8'h87
`define FN_ALL_LOCK 8'h8C
`define FN_TWO_LOCK 8'h8D
`define FN_MODE_BASE 8'h90
`define FN_CLAMP 8'h97
`define FN_HIST_AVAIL 8'h98
`define FN_HIST_UPD 8'h99
`define FN_FAULT_BASE 8'hA0
`define FN_VALID_BASE 8'hB0
`define FN_ACTIVE_BASE 8'hC0
`define FN_SYNC 8'hD0
`define FN_SOFT_CFG 8'hD1
// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define CLK_DIV_RATIO 32
`endif

// [core/pin_mux_pkg.sv]
// Purpose: types shared by the multifunction pin function select block
// Assumes: status bits arrive from logic on the system clock
// Notes: constants live in pin_mux_params.svh
package pin_mux_pkg;
  // --------------------------------------------------------------
  // status bundle mirrored onto the pin
  // --------------------------------------------------------------
  typedef struct packed {
    logic [2:0] mem_state;   // upload, download, fault
    logic [4:0] loop_state;  // sys lock, sys stable, out lock, cal, ref present
    logic [6:0] mode_state;  // free run .. phase slew limited
    logic freq_clamped;      // frequency clamped
    logic hist_avail;        // tuning word history available
    logic hist_updated;      // tuning word history updated
    logic [1:0] ref_active;  // active reference field
    logic [3:0] ref_fault;   // faults of refs a..d
    logic [3:0] ref_valid;   // valid of refs a..d
    logic sync_pulse;        // distribution sync pulse
    logic soft_cfg_busy;     // soft pin configuration running
    logic watchdog;          // watchdog timer output
  } status_bundle_t;
  // pin direction taken from the direction bit
  typedef enum logic {
    DIR_INPUT = 1'b0,
    DIR_OUTPUT = 1'b1
  } pin_dir_t;
  // decoded drive of the pin
  typedef struct packed {
    logic level;  // level when driven
    logic known;  // code is a defined function
  } pin_drive_t;
endpackage : pin_mux_pkg

// [tb/pin_board_model.sv]
// Purpose: board-side model of the multifunction pin
// Assumes: a pin released by the device has a board pull-down
// Notes: the resolved wire level is fed back to the device input
`timescale 1ns/1ns
module pin_board_model (
  input wire logic pin_out,
  input wire logic pin_oe_n,
  input wire logic drive_en,    // board drives a released pin
  input wire logic drive_level, // level the board drives
  output logic pin_level        // resolved wire, seen by both parties
);
  // --------------------------------------------------------------
  // wire resolution
  // --------------------------------------------------------------
  // device drive wins; the board never fights it, so no clash is modelled
  always_comb
  begin
    if (!pin_oe_n)
    begin
      pin_level = pin_out;
    end
    else
    begin
      // pull-down takes a line that nobody drives
      pin_level = drive_en ? drive_level : 1'b0;
    end
  end
endmodule : pin_board_model

// [tb/tb_top.sv]
// Purpose: self-checking bench for the multifunction pin select
// Assumes: design takes strobes at the edge after they are driven
// Notes: expectations are queued by the driver, compared by a monitor
`timescale 1ns/1ns
`include "pin_mux_params.svh"
module tb_top;
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  localparam int DIV = `CLK_DIV_RATIO;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  pin_mux_pkg::status_bundle_t status_i = '0;
  logic pin_in;
  logic pin_out;
  logic pin_oe_n;
  logic update_pulse;
  logic irq;
  logic board_en = 1'b0;   // board drives the pin
  logic board_lvl = 1'b0;
  logic smp = 1'b0;        // asks the monitor for a pin sample
  logic rd_d = 1'b0;       // read data due this cycle
  int errors = 0;
  int n_checks = 0;
  int seed = 25;
  logic [7:0] rd_q[$];     // expected read data
  logic [3:0] pin_q[$];    // {care of level, irq, oe_n, level}
  logic [7:0] upd_q[$];    // one note per expected update pulse
  // --------------------------------------------------------------
  // design and board
  // --------------------------------------------------------------
  multifunction_pin_function_select #(.DIV_RATIO(DIV)) multifunction_pin_function_select_inst (
    .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .status_i(status_i),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .update_pulse(update_pulse), .irq(irq));
  pin_board_model pin_board_model_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .drive_en(board_en), .drive_level(board_lvl), .pin_level(pin_in));
  // 4 ns period
  initial
  begin
    forever #2 clock = ~clock;
  end
  // --------------------------------------------------------------
  // reporting
  // --------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    if (errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // --------------------------------------------------------------
  // monitor: takes the oldest note when a result appears
  // --------------------------------------------------------------
  always @(posedge clock)
  begin
    rd_d <= reg_rd;
    if (rd_d)
      check(reg_rdata, rd_q.pop_front());
    if (smp)
    begin
      // level ignored while the pin is an input
      check({5'h00, irq, pin_oe_n, pin_q[0][3] ? pin_out : pin_q[0][0]},
            {5'h00, pin_q[0][2:0]});
      void'(pin_q.pop_front());
    end
    if (update_pulse)
      check(8'h01, (upd_q.size() > 0) ? upd_q.pop_front() : 8'h00);
  end
  // --------------------------------------------------------------
  // bus tasks
  // --------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rd_q.push_back(e);
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask : rd
  // settle three cycles past the last change, then sample once
  task automatic pchk(input logic [3:0] e);
    repeat (2) @(posedge clock);
    @(posedge clock);
    smp <= 1'b1;
    pin_q.push_back(e);
    @(posedge clock);
    smp <= 1'b0;
  endtask : pchk
  // --------------------------------------------------------------
  // expected pin for a code and status, irq masked off
  // --------------------------------------------------------------
  function automatic logic [3:0] exp_pin(input logic [7:0] c,
                                         input pin_mux_pkg::status_bundle_t s);
    logic v;
    v = 1'b0; // reserved output codes sit low
    if (!c[7])
      return 4'b0010; // released input
    if (c == `FN_OUT_HIGH) v = 1'b1;
    if (c == `FN_OUT_WDT) v = s.watchdog;
    if (c >= `FN_MEM_BASE && c <= 8'h86) v = s.mem_state[c - `FN_MEM_BASE];
    if (c >= `FN_LOOP_BASE && c <= 8'h8B) v = s.loop_state[c - `FN_LOOP_BASE];
    if (c == `FN_ALL_LOCK) v = s.mode_state[4] & s.loop_state[2] & s.loop_state[0];
    if (c == `FN_TWO_LOCK) v = s.mode_state[4] & s.loop_state[2];
    if (c >= `FN_MODE_BASE && c <= 8'h96) v = s.mode_state[c - `FN_MODE_BASE];
    if (c == `FN_CLAMP) v = s.freq_clamped;
    if (c == `FN_HIST_AVAIL) v = s.hist_avail;
    if (c == `FN_HIST_UPD) v = s.hist_updated;
    if (c >= `FN_FAULT_BASE && c <= 8'hA3) v = s.ref_fault[c[1:0]];
    if (c >= `FN_VALID_BASE && c <= 8'hB3) v = s.ref_valid[c[1:0]];
    if (c >= `FN_ACTIVE_BASE && c <= 8'hC3) v = (s.ref_active == c[1:0]);
    if (c == `FN_SYNC) v = s.sync_pulse;
    if (c == `FN_SOFT_CFG) v = s.soft_cfg_busy;
    return {3'b100, v};
  endfunction : exp_pin
  // --------------------------------------------------------------
  // hang guard
  // --------------------------------------------------------------
  initial
  begin
    repeat (100000) @(posedge clock);
    errors++;
    final_report();
  end
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    int i;
    int k;
    int hi;
    int tg;
    logic prev;
    logic [31:0] r;
    pin_mux_pkg::status_bundle_t st;
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    // reset values, pin released
    rd(`REG_FUNC, `FUNC_RESET);
    rd(`REG_IRQ_MASK, `MASK_RESET);
    rd(`REG_IRQ_STAT, 8'h00);
    pchk(4'b0010);
    // update trigger from a pin rise, raises irq with both status bits set
    wr(`REG_FUNC, `FN_IN_UPDATE);
    wr(`REG_IRQ_STAT, 8'hFF);
    wr(`REG_IRQ_MASK, 8'h01);
    rd(`REG_FUNC, `FN_IN_UPDATE);
    @(posedge clock);
    upd_q.push_back(8'h01);
    board_en <= 1'b1;
    board_lvl <= 1'b1;
    for (k = 0; k < 20 && upd_q.size() != 0; k++)
      @(posedge clock);
    if (upd_q.size() != 0)
    begin
      errors++;
      final_report();
    end
    pchk(4'b0110);
    rd(`REG_IRQ_STAT, 8'h03);
    rd(`REG_PIN_STATE, 8'h02);
    // masking hides and restores the level
    wr(`REG_IRQ_MASK, 8'h00);
    pchk(4'b0010);
    wr(`REG_IRQ_MASK, 8'h03);
    pchk(4'b0110);
    wr(`REG_IRQ_STAT, 8'h01);
    rd(`REG_IRQ_STAT, 8'h02);
    wr(`REG_IRQ_STAT, 8'h02);
    pchk(4'b0010);
    wr(`REG_IRQ_MASK, 8'h00);
    // idle input: a rise gives no pulse and no event
    board_lvl <= 1'b0;
    wr(`REG_FUNC, `FN_IN_IDLE);
    wr(`REG_IRQ_STAT, 8'hFF);
    @(posedge clock);
    board_lvl <= 1'b1;
    repeat (8) @(posedge clock);
    rd(`REG_IRQ_STAT, 8'h00);
    // unmapped place: reads zero, write ignored
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    rd(`REG_FUNC, `FN_IN_IDLE);
    board_en <= 1'b0;
    // every code once with random status; divider handled apart
    for (i = 0; i < 256; i++)
    begin
      if (i != `FN_OUT_DIV)
      begin
        r = $random(seed);
        st = r[$bits(st) - 1:0];
        @(posedge clock);
        status_i <= st;
        wr(`REG_FUNC, i[7:0]);
        pchk(exp_pin(i[7:0], st));
      end
    end
    // divided clock: half high, DIV cycle period
    wr(`REG_FUNC, `FN_OUT_DIV);
    repeat (4) @(posedge clock);
    @(negedge clock);
    prev = pin_out;
    hi = 0;
    tg = 0;
    for (k = 0; k < 2 * DIV; k++)
    begin
      @(negedge clock);
      hi += (pin_out === 1'b1);
      tg += (pin_out !== prev);
      prev = pin_out;
    end
    check(hi[7:0], 8'(DIV));
    check(tg[7:0], 8'h04);
    // sweep left only output level change events pending
    rd(`REG_IRQ_STAT, 8'h04);
    repeat (2) @(posedge clock);
    check(8'(upd_q.size()), 8'h00);
    final_report();
  end
endmodule : tb_top
